//--- verilog/mslm_motorless_sim.sv
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ps
module mslm_motorless_sim (
  input  wire logic                  ref_clk,
  input  wire logic                  arst_n,
  input  wire logic                  restartReq,   // restart pulse
  input  wire mslm_pkg::mslm_plant_t plant,
  input  wire logic                  extFeedback,  // loop on ext enc
  input  wire logic                  regenReq,
  input  wire logic                  dynBrakeReq,
  input  wire logic                  brakeReq,
  input  wire logic signed [7:0]     cmdStep,      // commanded motion
  input  wire logic [3:0]            regAddr,
  input  wire logic [15:0]           regWdata,
  input  wire logic                  regWr,
  input  wire logic                  regRd,
  output logic [31:0]                regRdata,
  output mslm_pkg::mslm_gate_t       gate,
  output logic                       brakeMonitor,
  output logic [3:0]                 statusDisp,
  output logic                       encAbsolute,
  output logic [4:0]                 encBits,
  output logic                       irq
);
  import mslm_pkg::*;

  logic [15:0]     setupReg;     // software copy of setup word
  mslm_mode_t      modeReg;      // latched at restart
  logic            cabSeenReg;   // started with cable attached
  logic            cabLostReg;   // cable left after start
  logic            restrictReg;  // motorless list only
  logic            cabPrevReg;   // cable level last cycle
  logic [19:0]     posReg;       // simulated encoder count
  logic [EV_N-1:0] irqStReg;     // sticky events
  logic [EV_N-1:0] irqMskReg;    // event mask
  logic [1:0]      fnResReg;     // last utility verdict
  logic [11:0]     fnCodeReg;    // last utility code
  logic [EV_N-1:0] evSet;        // events this cycle
  logic            fnPermit;     // decoded verdict
  logic            motorPresent; // motor counts as connected
  logic [3:0]      dispNext;     // next display code
  logic [19:0]     posNext;      // next position
  logic [19:0]     posMask;      // resolution wrap mask
  logic [31:0]     rdNext;       // read mux

  // strobes decoded
  wire wrSetup = regWr && regAddr == OFS_SETUP;
  wire wrIrqSt = regWr && regAddr == OFS_IRQST;
  wire wrMsk   = regWr && regAddr == OFS_IRQMSK;
  wire wrFn    = regWr && regAddr == OFS_FNREQ;
  wire simOn   = modeReg.enable;
  wire cabFall = cabPrevReg && !plant.cableOk;
  wire cabRise = !cabPrevReg && plant.cableOk;

  // software setup register, no effect until restart
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      setupReg <= SETUP_RST;
    end else if (wrSetup) begin
      setupReg <= regWdata;
    end
  end

  // mode cleared by reset, sampled only on restart
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      modeReg <= '0;
    end else if (restartReq) begin
      modeReg.enable   <= setupReg[DIG_EN+:4] == DIG_ONE;
      modeReg.hiRes    <= setupReg[DIG_RES+:4] == DIG_ONE;
      modeReg.absolute <= setupReg[DIG_TYP+:4] == DIG_ONE;
    end
  end

  // encoder cable history across the test
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cabPrevReg  <= 1'b0;
      cabSeenReg  <= 1'b0;
      cabLostReg  <= 1'b0;
      restrictReg <= 1'b0;
    end else begin
      cabPrevReg <= plant.cableOk;
      if (restartReq) begin
        // new test: remember cable at start
        cabSeenReg  <= plant.cableOk;
        cabLostReg  <= 1'b0;
        restrictReg <= 1'b0;
      end else if (simOn && cabSeenReg) begin
        if (cabFall) begin
          cabLostReg <= 1'b1;
        end
        if (cabRise && cabLostReg) begin
          restrictReg <= 1'b1;
        end
      end
    end
  end

  // motor counts present only if cable up and not restricted
  assign motorPresent = plant.cableOk && !restrictReg;

  // utility function permission decode
  always_comb begin
    fnPermit = 1'b0;
    case (regWdata[11:0])
      12'h000, 12'h002, 12'h003, 12'h004, 12'h005, 12'h006,
      12'h00c, 12'h00d, 12'h010, 12'h011, 12'h012, 12'h014,
      12'h01e, 12'h01f, 12'h030: begin
        fnPermit = 1'b1;
      end
      12'h008, 12'h00e, 12'h00f, 12'h013, 12'h020: begin
        fnPermit = motorPresent;
      end
      12'h01b, 12'h200, 12'h201, 12'h202, 12'h203,
      12'h204, 12'h205, 12'h206, 12'h207: begin
        fnPermit = 1'b0;
      end
      default: begin
        fnPermit = 1'b1; // outside the table: not restricted
      end
    endcase
    if (!simOn) begin
      fnPermit = 1'b1; // no limits in normal operation
    end
  end

  // utility request verdict
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fnResReg  <= 2'h0;
      fnCodeReg <= 12'h000;
    end else if (wrFn) begin
      fnResReg  <= fnPermit ? FN_OK : FN_REJ;
      fnCodeReg <= regWdata[11:0];
    end
  end

  // simulated position; absolute only on motor feedback
  assign posMask = modeReg.hiRes ? 20'hfffff : 20'h01fff;
  assign posNext = (posReg + {{12{cmdStep[7]}}, cmdStep}) & posMask;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      posReg <= 20'h00000;
    end else if (restartReq) begin
      posReg <= 20'h00000;
    end else if (simOn && plant.servoOn && !plant.alarm) begin
      posReg <= posNext;
    end
  end

  // display code priority: alarm, safety, travel, run/bb
  always_comb begin
    if (!simOn) begin
      dispNext = DSP_NONE;
    end else if (plant.alarm) begin
      dispNext = DSP_ALM;
    end else if (plant.safetyBb) begin
      dispNext = DSP_MARK | DSP_HBB;
    end else if (plant.fwdInhibit && plant.revInhibit) begin
      dispNext = DSP_MARK | DSP_PTNT;
    end else if (plant.fwdInhibit) begin
      dispNext = DSP_MARK | DSP_POT;
    end else if (plant.revInhibit) begin
      dispNext = DSP_MARK | DSP_NOT;
    end else if (plant.servoOn) begin
      dispNext = DSP_MARK | DSP_RUN;
    end else begin
      dispNext = DSP_MARK | DSP_BB;
    end
  end

  // events: rejected utility, cable drop in test
  assign evSet[EV_REJ] = wrFn && !fnPermit;
  assign evSet[EV_CAB] = simOn && cabFall;

  // sticky status, set beats write-one clear
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irqStReg  <= '0;
      irqMskReg <= '0;
    end else begin
      irqStReg <= (irqStReg & ~(wrIrqSt ? regWdata[EV_N-1:0] : '0))
                  | evSet;
      if (wrMsk) begin
        irqMskReg <= regWdata[EV_N-1:0];
      end
    end
  end

  // read mux
  always_comb begin
    case (regAddr)
      OFS_SETUP:  rdNext = {16'h0000, setupReg};
      OFS_STATUS: rdNext = {26'h0, restrictReg, motorPresent,
                            modeReg.absolute, modeReg.hiRes,
                            modeReg.enable, cabSeenReg};
      OFS_IRQST:  rdNext = {30'h0, irqStReg};
      OFS_IRQMSK: rdNext = {30'h0, irqMskReg};
      OFS_POS:    rdNext = {12'h000, posReg};
      OFS_FNREQ:  rdNext = {18'h0, fnResReg, fnCodeReg};
      default:    rdNext = 32'h00000000;
    endcase
  end

  // registered outputs
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdata     <= 32'h00000000;
      gate         <= '0;
      brakeMonitor <= 1'b0;
      statusDisp   <= DSP_NONE;
      encAbsolute  <= 1'b0;
      encBits      <= RES_LOW;
      irq          <= 1'b0;
    end else begin
      regRdata        <= regRd ? rdNext : 32'h00000000;
      gate.regenEn    <= regenReq && !simOn;
      gate.dynBrakeEn <= dynBrakeReq && !simOn;
      gate.brakeDrive <= brakeReq && !simOn;
      brakeMonitor    <= brakeReq;
      statusDisp      <= dispNext;
      encAbsolute     <= modeReg.absolute && !extFeedback;
      encBits         <= modeReg.hiRes ? RES_HIGH : RES_LOW;
      irq             <= |((irqStReg | evSet) & irqMskReg);
    end
  end

  // checks, one cycle after each cause
  regen_off_a: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    simOn |=> !gate.regenEn && !gate.dynBrakeEn)
    else $error("power stage active in test");

  brake_off_a: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    simOn && brakeReq |=> !gate.brakeDrive && brakeMonitor)
    else $error("brake driven in test");

  alarm_disp_a: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    simOn && plant.alarm |=> statusDisp == DSP_ALM)
    else $error("marker shown during alarm");

  tune_rej_a: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    simOn && wrFn && regWdata[11:0] == 12'h01b |=> fnResReg == FN_REJ)
    else $error("tuning function accepted");

  mode_hold_a: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    !restartReq |=> $stable(modeReg))
    else $error("mode changed without restart");

  ext_incr_a: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    extFeedback |=> !encAbsolute)
    else $error("external encoder absolute");

  en_latch_a: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    restartReq && setupReg[DIG_EN+:4] == DIG_ONE |=> modeReg.enable)
    else $error("test mode not enabled");

  en_clear_a: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    restartReq && setupReg[DIG_EN+:4] != DIG_ONE |=> !modeReg.enable)
    else $error("test mode enabled by other digit");

  res_high_a: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    restartReq && setupReg[DIG_RES+:4] == DIG_ONE |=> modeReg.hiRes)
    else $error("high resolution not latched");

  res_low_a: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    restartReq && setupReg[DIG_RES+:4] != DIG_ONE |=> !modeReg.hiRes)
    else $error("low resolution not latched");

  type_abs_a: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    restartReq && setupReg[DIG_TYP+:4] == DIG_ONE |=> modeReg.absolute)
    else $error("absolute type not latched");

  type_inc_a: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    !modeReg.absolute |=> !encAbsolute)
    else $error("absolute shown for incremental");

  bits_out_a: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    modeReg.hiRes |=> encBits == RES_HIGH)
    else $error("resolution output wrong");

  off_pass_a: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    !simOn && regenReq |=> gate.regenEn)
    else $error("regeneration blocked outside test");

  restrict_rej_a: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    simOn && restrictReg && wrFn && regWdata[11:0] == 12'h008
    |=> fnResReg == FN_REJ)
    else $error("motor function accepted after reconnect");

  common_ok_a: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    simOn && wrFn && regWdata[11:0] == 12'h030 |=> fnResReg == FN_OK)
    else $error("common function rejected");

  motor_fn_a: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    simOn && !motorPresent && wrFn && regWdata[11:0] == 12'h020
    |=> fnResReg == FN_REJ)
    else $error("motor function accepted without motor");

  vib_rej_a: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    simOn && wrFn && regWdata[11:0] == 12'h207 |=> fnResReg == FN_REJ)
    else $error("vibration function accepted");

  marker_on_a: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    simOn && !plant.alarm |=> (statusDisp & DSP_MARK) == DSP_MARK)
    else $error("marker missing in test");

  run_disp_a: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    simOn && !plant.alarm && !plant.safetyBb && !plant.fwdInhibit
    && !plant.revInhibit && plant.servoOn
    |=> statusDisp == (DSP_MARK | DSP_RUN))
    else $error("run status not shown");

  hbb_disp_a: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    simOn && !plant.alarm && plant.safetyBb
    |=> statusDisp == (DSP_MARK | DSP_HBB))
    else $error("safety status not shown");

  pos_hold_a: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    !restartReq && !simOn |=> $stable(posReg))
    else $error("position moved outside test");

  ev_sticky_a: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    evSet[EV_REJ] |=> irqStReg[EV_REJ])
    else $error("rejection event lost");
endmodule : mslm_motorless_sim

//--- verilog/mslm_pkg.sv
package mslm_pkg;
  // register offsets on the plain port
  localparam logic [3:0] OFS_SETUP  = 4'h0;  // sim_setup_word
  localparam logic [3:0] OFS_STATUS = 4'h1;  // live state
  localparam logic [3:0] OFS_IRQST  = 4'h2;  // sticky events
  localparam logic [3:0] OFS_IRQMSK = 4'h3;  // event mask
  localparam logic [3:0] OFS_POS    = 4'h4;  // simulated position
  localparam logic [3:0] OFS_FNREQ  = 4'h5;  // utility request/result
  // setup word digit positions (4 bits per digit)
  localparam int DIG_EN  = 0;
  localparam int DIG_RES = 4;
  localparam int DIG_TYP = 8;
  localparam logic [15:0] SETUP_RST = 16'h0000;
  localparam logic [3:0]  DIG_ONE   = 4'h1;
  // encoder resolutions in bits
  localparam logic [4:0] RES_LOW  = 5'd13;
  localparam logic [4:0] RES_HIGH = 5'd20;
  // status display codes, marker in bit 3
  localparam logic [3:0] DSP_MARK = 4'h8;
  localparam logic [3:0] DSP_NONE = 4'h0;
  localparam logic [3:0] DSP_ALM  = 4'h1;
  localparam logic [3:0] DSP_RUN  = 4'h0;
  localparam logic [3:0] DSP_BB   = 4'h1;
  localparam logic [3:0] DSP_PTNT = 4'h2;
  localparam logic [3:0] DSP_POT  = 4'h3;
  localparam logic [3:0] DSP_NOT  = 4'h4;
  localparam logic [3:0] DSP_HBB  = 4'h5;
  // event bits
  localparam int EV_REJ = 0;
  localparam int EV_CAB = 1;
  localparam int EV_N   = 2;
  // utility function result codes
  localparam logic [1:0] FN_OK  = 2'h1;
  localparam logic [1:0] FN_REJ = 2'h2;

  // latched mode fields
  typedef struct packed {
    logic       enable;
    logic       hiRes;
    logic       absolute;
  } mslm_mode_t;

  // plant inputs seen by the block
  typedef struct packed {
    logic       servoOn;
    logic       fwdInhibit;
    logic       revInhibit;
    logic       safetyBb;
    logic       alarm;
    logic       cableOk;
  } mslm_plant_t;

  // power stage gating outputs
  typedef struct packed {
    logic       regenEn;
    logic       dynBrakeEn;
    logic       brakeDrive;
  } mslm_gate_t;
endpackage : mslm_pkg

//--- test/mslm_host_model.sv
`timescale 1ns/1ps
// host side: sends one motion step per cycle and keeps the running sum
module mslm_host_model (
  input  wire logic         ref_clk,
  input  wire logic         arst_n,
  input  wire logic         moveEn,    // host commands motion
  input  wire logic [7:0]   stepIn,    // next step to send
  output logic signed [7:0] cmdStep,   // step toward the drive
  output logic [19:0]       commanded  // sum of all steps sent
);
  // step goes out, sum grows by the sign-extended step
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cmdStep   <= 8'sh00;
      commanded <= 20'h00000;
    end else if (moveEn) begin
      cmdStep   <= $signed(stepIn);
      commanded <= commanded + {{12{stepIn[7]}}, stepIn};
    end else begin
      cmdStep   <= 8'sh00;
    end
  end
endmodule : mslm_host_model

//--- test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import mslm_pkg::*;
  logic               ref_clk, arst_n, restartReq, extFeedback, moveEn;
  logic               regenReq, dynBrakeReq, brakeReq, regWr, regRd;
  logic               brakeMonitor, encAbsolute, irq, rdPend;
  mslm_plant_t        plant;
  mslm_gate_t         gate;
  logic signed [7:0]  cmdStep;
  logic [7:0]         stepIn;
  logic [19:0]        commanded;
  logic [3:0]         regAddr, statusDisp;
  logic [15:0]        regWdata;
  logic [31:0]        regRdata, rng;
  logic [4:0]         encBits;
  logic [31:0]        expQ[$];  // expected read data, oldest first
  int                 err_count, n_tests, cycles;
  // plant patterns {servoOn,fwd,rev,safety,alarm,cable} and display
  logic [5:0]  pv [7] = '{6'h21, 6'h01, 6'h19, 6'h11, 6'h09, 6'h05, 6'h23};
  logic [3:0]  dv [7] = '{4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'h1};
  logic [11:0] okFn [20] = '{12'h000, 12'h002, 12'h003, 12'h004, 12'h005,
    12'h006, 12'h00c, 12'h00d, 12'h010, 12'h011, 12'h012, 12'h014,
    12'h01e, 12'h01f, 12'h030, 12'h008, 12'h00e, 12'h00f, 12'h013, 12'h020};

  mslm_motorless_sim uut (.ref_clk(ref_clk), .arst_n(arst_n),
    .restartReq(restartReq), .plant(plant), .extFeedback(extFeedback),
    .regenReq(regenReq), .dynBrakeReq(dynBrakeReq), .brakeReq(brakeReq),
    .cmdStep(cmdStep), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .gate(gate),
    .brakeMonitor(brakeMonitor), .statusDisp(statusDisp),
    .encAbsolute(encAbsolute), .encBits(encBits), .irq(irq));
  mslm_host_model host (.ref_clk(ref_clk), .arst_n(arst_n),
    .moveEn(moveEn), .stepIn(stepIn), .cmdStep(cmdStep),
    .commanded(commanded));

  // free-running clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // verdict and end of run
  task automatic finish_test;
    if (err_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test

  // one comparison, mismatch printed at once
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // xorshift generator
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  // idle cycles with strobes low
  task automatic cyc(input int n);
    regWr <= 1'b0;
    regRd <= 1'b0;
    repeat (n) @(posedge ref_clk);
  endtask : cyc

  // register write, one cycle
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    regAddr  <= a;
    regWdata <= d;
    regRd    <= 1'b0;
    regWr    <= 1'b1;
    @(posedge ref_clk);
  endtask : wr

  // register read, expectation queued for the watcher
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    regAddr <= a;
    regWr   <= 1'b0;
    regRd   <= 1'b1;
    expQ.push_back(e);
    @(posedge ref_clk);
  endtask : rd

  // restart pulse, then let mode and outputs settle
  task automatic restart;
    restartReq <= 1'b1;
    cyc(1);
    restartReq <= 1'b0;
    cyc(3);
  endtask : restart

  // utility request and its result
  task automatic fn(input logic [11:0] c, input logic [1:0] r);
    wr(OFS_FNREQ, {4'h0, c});
    cyc(1);
    rd(OFS_FNREQ, {18'h0, r, c});
  endtask : fn

  // watcher: read data stands the cycle after the strobe
  always @(posedge ref_clk) begin
    if (rdPend)
      chk("regRdata", expQ.pop_front(), regRdata);
    rdPend = regRd;
  end

  // hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      finish_test();
    end
  end

  // main sequence
  initial begin
    {arst_n, restartReq, extFeedback, moveEn, regWr, regRd} = '0;
    {regenReq, dynBrakeReq, brakeReq, rdPend} = '0;
    {plant, stepIn, regAddr, regWdata} = '0;
    rng = 32'd75313;
    repeat (5) @(posedge ref_clk);
    arst_n <= 1'b1;
    cyc(1);
    chk("encBits", 32'(RES_LOW), 32'(encBits));
    rd(OFS_SETUP, 32'(SETUP_RST));
    rd(4'hf, 32'h0);
    // mode off: gating follows requests
    {regenReq, dynBrakeReq, brakeReq} <= 3'b111;
    cyc(2);
    chk("gate", 32'h7, 32'(gate));
    wr(OFS_SETUP, 16'h0111);
    plant <= mslm_plant_t'(6'h21);
    restart();
    chk("gate", 32'h0, 32'(gate));
    chk("brakeMonitor", 32'h1, 32'(brakeMonitor));
    chk("encBits", 32'(RES_HIGH), 32'(encBits));
    chk("encAbsolute", 32'h1, 32'(encAbsolute));
    extFeedback <= 1'b1;
    cyc(2);
    chk("encAbsolute", 32'h0, 32'(encAbsolute));
    extFeedback <= 1'b0;
    // setup changed without restart keeps the latched mode
    wr(OFS_SETUP, 16'h0000);
    cyc(3);
    chk("encBits", 32'(RES_HIGH), 32'(encBits));
    wr(OFS_SETUP, 16'h0111);
    cyc(1);
    // random motion, position must track the sum
    moveEn <= 1'b1;
    repeat (40) begin
      stepIn <= rng[7:0];
      rng = xs(rng);
      @(posedge ref_clk);
    end
    moveEn <= 1'b0;
    cyc(3);
    rd(OFS_POS, {12'h0, commanded});
    cyc(1);
    // display codes per plant condition
    for (int i = 0; i < 7; i++) begin
      plant <= mslm_plant_t'(pv[i]);
      cyc(2);
      chk("statusDisp", 32'(dv[i]), 32'(statusDisp));
    end
    plant <= mslm_plant_t'(6'h21);
    cyc(2);
    for (int i = 0; i < 20; i++) fn(okFn[i], FN_OK);
    fn(12'h01b, FN_REJ);
    for (int i = 0; i < 8; i++) fn(12'h200 + 12'(i), FN_REJ);
    // cable dropped and back: motorless list only
    plant.cableOk <= 1'b0;
    cyc(2);
    plant.cableOk <= 1'b1;
    cyc(2);
    fn(12'h008, FN_REJ);
    fn(12'h000, FN_OK);
    cyc(1);
    chk("irq", 32'h0, 32'(irq));
    wr(OFS_IRQMSK, 16'h0003);
    cyc(2);
    chk("irq", 32'h1, 32'(irq));
    rd(OFS_IRQST, 32'h3);
    wr(OFS_IRQST, 16'h0003);
    cyc(2);
    chk("irq", 32'h0, 32'(irq));
    rd(OFS_IRQST, 32'h0);
    cyc(3);
    finish_test();
  end
endmodule : tb_top
